//--- shared/llm_pkg.sv
// Purpose: Constants and types for the light-load mode and power-good controller
// Assumes: Voltages arrive as unsigned codes of 1/256 V per LSB, 16 bits wide
// Notes:   Timing counts derive from the 10 MHz controller clock
//
// How it works
// [R1] Feed-forward is off below 4.7 V input supply, on at or above.
// [R2] Without management bus, light-load allowed only with force-continuous bit at 0.
// [R3] SVID with force-continuous cleared: enter light load by load, no command needed.
// [R4] SVID with force-continuous set: PS2-PS4 allow light load; PS0, PS1, VID up forbid.
// [R5] Override enable 1, override value 0, force-continuous 1 forbids light load entirely.
// [R6] After reference ramp, sample error-amp level, hold in register, drive DAC.
// [R7] Enter light load after 8 consecutive cycles with zero crossing sensed.
// [R8] Light load: fixed pulse, low side until zero current, idle until sense hits reference.
// [R9] Sense at reference but current positive: delay next pulse until current is zero.
// [R10] Leave light load when output falls to 95 percent of reference.
// [R11] Leave light load when sense below reference over 3 consecutive zero crossings.
// [R12] Block light load during voltage transitions until ramp done and level re-held.
// [R13] Telemetry comes from the sense input at 1/256 V resolution.
// [R14] Overvoltage warning and undervoltage fault/warning compare digitized sense to limits.
// [R15] Management-bus mode: power good high while sense is inside programmed window.
// [R16] Threshold more than 630 mV from output is replaced by 630 mV tracking offset.
// [R17] Power good asserts at window entry by default; digital delay 0 to 10 ms.
// [R18] SVID mode: ignore window, assert once output within boot voltage tolerance.
// [R19] SVID mode: power good stays high; drops on fault or optional 0 V command.
// [R20] Configuring party should prefer forced continuous conduction where practical.
// [R21] Sense leaving window during delay restarts count and keeps power good low.
package llm_pkg;
    localparam int unsigned CLK_HZ         = 10_000_000;
    localparam int unsigned VW             = 16;
    localparam logic [15:0] FF_MIN_CODE    = 16'h04B3;  // 4.7 V in 1/256 V
    localparam logic [15:0] PG_TRACK_CODE  = 16'h00A1;  // 630 mV in 1/256 V
    localparam int unsigned PG_STEP_MS     = 1;
    localparam int unsigned PG_STEP_CYC    = CLK_HZ / 1000 * PG_STEP_MS;
    localparam logic [3:0]  PG_DLY_MAX     = 4'hA;
    localparam int unsigned ENTRY_ZC       = 8;
    localparam int unsigned EXIT_ZC        = 3;
    localparam logic [6:0]  EXIT_PCT       = 7'h5F;     // 95 percent
    localparam logic [2:0]  PS_ZERO        = 3'h0;
    localparam logic [2:0]  PS_ONE         = 3'h1;
    localparam int unsigned ONW            = 8;

    typedef enum logic [1:0]
    {
        LLM_PWM   = 2'b00,
        LLM_ON    = 2'b01,
        LLM_LOW   = 2'b10,
        LLM_IDLE  = 2'b11
    } llm_state_t;
endpackage : llm_pkg

//--- rtl/llm_ctrl.sv
// Purpose: Light-load mode selection, sense supervision and power-good control
// Assumes: All inputs synchronous to mclk; analog compare results arrive as levels
// Notes:   Power-good pin is open drain, pulled low while pg_oe_n is low
`timescale 1ns/1ps
module llm_ctrl #(
    parameter int unsigned PG_STEP_CYC = llm_pkg::PG_STEP_CYC,
    parameter int unsigned ONW         = llm_pkg::ONW
) (
    input  wire logic                   mclk,
    input  wire logic                   reset_n,
    input  wire logic [15:0]            input_supply_voltage,
    output logic                        feed_forward_en,
    input  wire logic                   svid_mode,
    input  wire logic                   mgmt_bus_variant,
    input  wire logic                   mfr_aot_enable,
    input  wire logic                   force_continuous,
    input  wire logic                   power_state_override_enable,
    input  wire logic [2:0]             power_state_override_value,
    input  wire logic                   ps_cmd_valid,
    input  wire logic [2:0]             ps_cmd_state,
    input  wire logic                   vid_up_cmd,
    input  wire logic                   vid_zero_cmd,
    input  wire logic                   pg_drop_on_zero,
    input  wire logic                   ref_ramping,
    input  wire logic                   cal_done,
    input  wire logic [7:0]             error_amp_code,
    output logic [7:0]                  cal_dac_ff,
    output logic                        cal_valid_ff,
    input  wire logic                   switch_cycle,
    input  wire logic                   zero_cross,
    input  wire logic                   current_zero,
    input  wire logic                   feedback_input,
    input  wire logic [15:0]            sense_code,
    input  wire logic [15:0]            ref_code,
    input  wire logic [ONW-1:0]         on_width,
    output logic                        adaptive_on_time_mode,
    output logic                        high_side_drive,
    output logic                        low_side_drive,
    output logic [15:0]                 vout_telemetry_ff,
    input  wire logic [15:0]            ov_warn_limit,
    input  wire logic [15:0]            uv_fault_limit,
    input  wire logic [15:0]            uv_warn_limit,
    output logic                        ov_warn_ff,
    output logic                        uv_fault_ff,
    output logic                        uv_warn_ff,
    input  wire logic [15:0]            pg_on_code,
    input  wire logic [15:0]            pg_off_code,
    input  wire logic [15:0]            vout_code,
    input  wire logic                   pg_delay_en,
    input  wire logic [3:0]             power_good_delay_command,
    input  wire logic                   boot_in_tolerance,
    input  wire logic                   conversion_fault,
    output logic                        power_good_output,
    output logic                        pg_oe_n
);
    initial
    begin
        if (ONW < 2 || ONW > 16 || PG_STEP_CYC < 1)
            $error("llm_ctrl: unsupported parameter values");
    end

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    function automatic logic [15:0] clamp_thr(input logic [15:0] thr, input logic [15:0] vo);
        logic [15:0] lim;
        lim = (vo > llm_pkg::PG_TRACK_CODE) ? vo - llm_pkg::PG_TRACK_CODE : 16'h0000;
        clamp_thr = (thr < lim) ? lim : thr;
    endfunction : clamp_thr

    // ------------------------------------------------------------
    // Feed-forward and telemetry
    // ------------------------------------------------------------
    assign feed_forward_en = (input_supply_voltage >= llm_pkg::FF_MIN_CODE); // see [R1]

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            vout_telemetry_ff <= 16'h0000;
            ov_warn_ff        <= 1'b0;
            uv_fault_ff       <= 1'b0;
            uv_warn_ff        <= 1'b0;
        end
        else
        begin
            vout_telemetry_ff <= sense_code;                      // see [R13]
            ov_warn_ff        <= (sense_code > ov_warn_limit);    // see [R14]
            uv_fault_ff       <= (sense_code < uv_fault_limit);   // see [R14]
            uv_warn_ff        <= (sense_code < uv_warn_limit);    // see [R14]
        end
    end

    // ------------------------------------------------------------
    // Calibration hold
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cal_dac_ff   <= 8'h00;
            cal_valid_ff <= 1'b0;
        end
        else if (ref_ramping)
            cal_valid_ff <= 1'b0;                  // see [R12]
        else if (cal_done && !cal_valid_ff)
        begin
            cal_dac_ff   <= error_amp_code;        // see [R6]
            cal_valid_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Light-load permission
    // ------------------------------------------------------------
    logic ps_allow_ff;
    logic permit;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            ps_allow_ff <= 1'b0;
        else if (vid_up_cmd || (ps_cmd_valid && (ps_cmd_state == llm_pkg::PS_ZERO ||
                                                 ps_cmd_state == llm_pkg::PS_ONE)))
            ps_allow_ff <= 1'b0;                   // see [R4]
        else if (ps_cmd_valid)
            ps_allow_ff <= 1'b1;                   // see [R4]
    end

    always_comb
    begin
        permit = 1'b0;
        if (svid_mode)
        begin
            if (!force_continuous)
                permit = 1'b1;                     // see [R3]
            else if (power_state_override_enable)
                permit = (power_state_override_value != llm_pkg::PS_ZERO) &&
                         (power_state_override_value != llm_pkg::PS_ONE); // see [R5]
            else
                permit = ps_allow_ff;              // see [R4]
        end
        else if (mgmt_bus_variant)
            permit = mfr_aot_enable;               // see [R2]
        else
            permit = !force_continuous;            // see [R2]
        permit = permit && cal_valid_ff && !ref_ramping; // see [R6] see [R12]
    end

    // ------------------------------------------------------------
    // Mode state machine
    // ------------------------------------------------------------
    llm_pkg::llm_state_t state_ff;
    logic [3:0]          zc_cnt_ff;
    logic [1:0]          below_cnt_ff;
    logic [ONW-1:0]      on_cnt_ff;
    logic [22:0]         low95;
    logic                drop95;

    assign low95  = 23'(ref_code) * 23'(llm_pkg::EXIT_PCT);
    assign drop95 = (23'(sense_code) * 23'h64) <= low95;   // see [R10]

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            zc_cnt_ff <= 4'h0;
        else if (state_ff != llm_pkg::LLM_PWM)
            zc_cnt_ff <= 4'h0;
        else if (switch_cycle)
            zc_cnt_ff <= zero_cross ? ((zc_cnt_ff == 4'(llm_pkg::ENTRY_ZC)) ? zc_cnt_ff
                                        : zc_cnt_ff + 4'h1) : 4'h0; // see [R7]
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            below_cnt_ff <= 2'h0;
        else if (state_ff == llm_pkg::LLM_PWM)
            below_cnt_ff <= 2'h0;
        else if (zero_cross)
            below_cnt_ff <= (sense_code < ref_code) ? below_cnt_ff + 2'h1 : 2'h0; // see [R11]
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_ff  <= llm_pkg::LLM_PWM;
            on_cnt_ff <= '0;
        end
        else if (state_ff != llm_pkg::LLM_PWM && (!permit || drop95 ||
                 (zero_cross && sense_code < ref_code &&
                  below_cnt_ff == 2'(llm_pkg::EXIT_ZC - 1))))
            state_ff <= llm_pkg::LLM_PWM;          // see [R10] see [R11] see [R12]
        else
        begin
            case (state_ff)
                llm_pkg::LLM_PWM:
                begin
                    if (permit && zc_cnt_ff == 4'(llm_pkg::ENTRY_ZC))
                        state_ff <= llm_pkg::LLM_IDLE; // see [R7]
                end
                llm_pkg::LLM_ON:
                begin
                    if (on_cnt_ff >= on_width)
                        state_ff <= llm_pkg::LLM_LOW; // see [R8]
                    else
                        on_cnt_ff <= on_cnt_ff + 1'b1;
                end
                llm_pkg::LLM_LOW:
                begin
                    if (current_zero)
                        state_ff <= llm_pkg::LLM_IDLE; // see [R8]
                end
                llm_pkg::LLM_IDLE:
                begin
                    if (sense_code <= ref_code && current_zero) // see [R8] see [R9]
                    begin
                        state_ff  <= llm_pkg::LLM_ON;
                        on_cnt_ff <= '0;
                    end
                end
                default: state_ff <= llm_pkg::LLM_PWM;
            endcase
        end
    end

    assign adaptive_on_time_mode = (state_ff != llm_pkg::LLM_PWM);
    assign high_side_drive = (state_ff == llm_pkg::LLM_ON);
    assign low_side_drive  = (state_ff == llm_pkg::LLM_LOW);

    AST_NO_PULSE_WHILE_CURRENT: assert property (@(posedge mclk) disable iff (!reset_n)
        (state_ff == llm_pkg::LLM_IDLE && !current_zero) |=> state_ff != llm_pkg::LLM_ON)
        else $error("pulse started with current positive"); // see [R9]
    AST_ENTRY_NEEDS_PERMIT: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(adaptive_on_time_mode) |-> $past(permit) && $past(zc_cnt_ff) == 4'h8)
        else $error("light load entered without eight crossings"); // see [R7]
    AST_EXIT_ON_DROP: assert property (@(posedge mclk) disable iff (!reset_n)
        (adaptive_on_time_mode && drop95) |=> !adaptive_on_time_mode)
        else $error("light load held below 95 percent"); // see [R10]
    AST_NO_LLM_IN_RAMP: assert property (@(posedge mclk) disable iff (!reset_n)
        ref_ramping |=> !adaptive_on_time_mode)
        else $error("light load during ramp"); // see [R12]
    AST_FF_THRESHOLD: assert property (@(posedge mclk) disable iff (!reset_n)
        feed_forward_en == (input_supply_voltage >= 16'h04B3))
        else $error("feed-forward threshold wrong"); // see [R1]
    AST_FORBID_ALL: assert property (@(posedge mclk) disable iff (!reset_n)
        (svid_mode && force_continuous && power_state_override_enable &&
         power_state_override_value == 3'h0) [*2] |-> !adaptive_on_time_mode)
        else $error("light load not forbidden"); // see [R5]

    // ------------------------------------------------------------
    // Power good
    // ------------------------------------------------------------
    logic [15:0] thr_on;
    logic [15:0] thr_off;
    logic        in_win;
    logic [3:0]  ms_cnt_ff;
    logic [23:0] step_cnt_ff;
    logic        pg_ff;

    assign thr_on  = clamp_thr(pg_on_code, vout_code);  // see [R16]
    assign thr_off = clamp_thr(pg_off_code, vout_code); // see [R16]
    assign in_win  = pg_ff ? (sense_code >= thr_off) : (sense_code >= thr_on); // see [R15]

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pg_ff       <= 1'b0;
            ms_cnt_ff   <= 4'h0;
            step_cnt_ff <= 24'h000000;
        end
        else if (svid_mode)
        begin
            ms_cnt_ff   <= 4'h0;
            step_cnt_ff <= 24'h000000;
            if (conversion_fault || (pg_drop_on_zero && vid_zero_cmd))
                pg_ff <= 1'b0;                     // see [R19]
            else if (boot_in_tolerance)
                pg_ff <= 1'b1;                     // see [R18]
        end
        else if (!in_win || conversion_fault)
        begin
            pg_ff       <= 1'b0;                   // see [R21]
            ms_cnt_ff   <= 4'h0;
            step_cnt_ff <= 24'h000000;
        end
        else if (!pg_ff)
        begin
            if (!pg_delay_en || ms_cnt_ff >= power_good_delay_command ||
                ms_cnt_ff >= llm_pkg::PG_DLY_MAX)
                pg_ff <= 1'b1;                     // see [R17]
            else if (step_cnt_ff == 24'(PG_STEP_CYC - 1))
            begin
                step_cnt_ff <= 24'h000000;
                ms_cnt_ff   <= ms_cnt_ff + 4'h1;
            end
            else
                step_cnt_ff <= step_cnt_ff + 24'h000001;
        end
    end

    assign power_good_output = pg_ff;
    assign pg_oe_n           = pg_ff;

    AST_PG_DROP_OUT: assert property (@(posedge mclk) disable iff (!reset_n)
        (!svid_mode && !in_win) |=> !power_good_output)
        else $error("power good high outside window"); // see [R15] see [R21]
    AST_PG_SVID_HOLD: assert property (@(posedge mclk) disable iff (!reset_n)
        (svid_mode && power_good_output && !conversion_fault && !vid_zero_cmd)
        |=> power_good_output)
        else $error("power good dropped in SVID mode"); // see [R19]
    AST_PG_NO_DELAY: assert property (@(posedge mclk) disable iff (!reset_n)
        (!svid_mode && !pg_delay_en && in_win && !conversion_fault) |=> power_good_output)
        else $error("power good late without delay"); // see [R17]
endmodule : llm_ctrl

//--- testbench/llm_host_model.sv
// Purpose: Host issuing power-state and VID commands as one-cycle pulses
// Assumes: cmd_go high one cycle per command
// Notes:   Kind 1 power state, 2 VID increase, 3 VID to 0 V
`timescale 1ns/1ps
module llm_host_model (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       cmd_go,
    input  wire logic [1:0] cmd_kind,
    input  wire logic [2:0] cmd_ps,
    output logic            ps_cmd_valid,
    output logic [2:0]      ps_cmd_state,
    output logic            vid_up_cmd,
    output logic            vid_zero_cmd
);
    //--------------------------------------------------------------
    // Command strobes
    //--------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ps_cmd_valid <= 1'h0;
            vid_up_cmd   <= 1'h0;
            vid_zero_cmd <= 1'h0;
            ps_cmd_state <= 3'h0;
        end
        else
        begin
            ps_cmd_valid <= cmd_go && (cmd_kind == 2'h1);
            vid_up_cmd   <= cmd_go && (cmd_kind == 2'h2);
            vid_zero_cmd <= cmd_go && (cmd_kind == 2'h3);
            ps_cmd_state <= (cmd_go && cmd_kind == 2'h1) ? cmd_ps : ~ps_cmd_state;
        end
    end
endmodule : llm_host_model

//--- testbench/light_load_mode_and_power_good_control_bench.sv
// Purpose: Self-checking bench for the light-load and power-good controller
// Assumes: Power-good step shortened to 10 cycles per ms
// Notes:   Drive on rising edges, sample on falling
`timescale 1ns/1ps
module light_load_mode_and_power_good_control_bench;
    //--------------------------------------------------------------
    // Signals
    //--------------------------------------------------------------
    localparam int unsigned STEP = 10;
    logic mclk = 1'h0;
    logic reset_n, svid_mode, mgmt_bus_variant, mfr_aot_enable, force_continuous;
    logic power_state_override_enable, pg_drop_on_zero, ref_ramping, cal_done;
    logic switch_cycle, zero_cross, current_zero, feedback_input, pg_delay_en;
    logic boot_in_tolerance, conversion_fault, cmd_go, ps_cmd_valid, vid_up_cmd;
    logic vid_zero_cmd, feed_forward_en, cal_valid_ff, adaptive_on_time_mode;
    logic high_side_drive, low_side_drive, ov_warn_ff, uv_fault_ff, uv_warn_ff;
    logic power_good_output, pg_oe_n;
    logic allow = 1'h0;
    logic [1:0] cmd_kind;
    logic [2:0] power_state_override_value, ps_cmd_state, cmd_ps;
    logic [3:0] power_good_delay_command;
    logic [7:0] error_amp_code, cal_dac_ff;
    logic [llm_pkg::ONW-1:0] on_width;
    logic [15:0] input_supply_voltage, sense_code, ref_code, vout_code, vout_telemetry_ff;
    logic [15:0] ov_warn_limit, uv_fault_limit, uv_warn_limit, pg_on_code, pg_off_code;
    integer fails = 0, num_checks = 0, seed = 32'hBD2C4154, i, n;

    always #50 mclk = ~mclk;
    llm_ctrl #(.PG_STEP_CYC(STEP), .ONW(llm_pkg::ONW)) DUT (.*);
    llm_host_model HOST (.*);

    //--------------------------------------------------------------
    // Tasks
    //--------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic look(input int c);
        repeat (c) @(posedge mclk);
        @(negedge mclk);
    endtask : look

    task automatic pulses(input int c, input logic sc, input logic z);
        repeat (c)
        begin
            @(posedge mclk);
            switch_cycle <= sc;
            zero_cross   <= z;
            @(posedge mclk);
            switch_cycle <= 1'h0;
            zero_cross   <= 1'h0;
        end
    endtask : pulses

    task automatic calib(input logic fin);
        @(posedge mclk);
        ref_ramping    <= 1'h1;
        error_amp_code <= 8'($random(seed));
        look(3);
        check(cal_valid_ff, 1'h0);
        @(posedge mclk);
        ref_ramping <= 1'h0;
        cal_done    <= fin;
        @(posedge mclk);
        cal_done <= 1'h0;
    endtask : calib

    task automatic host(input logic [1:0] k, input logic [2:0] p);
        @(posedge mclk);
        cmd_go   <= 1'h1;
        cmd_kind <= k;
        cmd_ps   <= p;
        @(posedge mclk);
        cmd_go <= 1'h0;
        if (k == 2'h1)
            allow = (p >= 3'h2);
        if (k == 2'h2)
            allow = 1'h0;
    endtask : host

    function automatic logic llm_exp(input logic [4:0] c, input logic [2:0] ov);
        if (!c[4])
            return c[3] ? c[2] : !c[1];
        if (!c[1])
            return 1'h1;
        if (c[0])
            return ov >= 3'h2;
        return allow;
    endfunction : llm_exp

    // Bits: svid, mgmt, mfr enable, force cont., override
    task automatic mode_case(input logic [4:0] c, input logic [2:0] ov,
                             input logic [1:0] k, input logic [2:0] p);
        @(posedge mclk);
        {svid_mode, mgmt_bus_variant, mfr_aot_enable} <= c[4:2];
        {force_continuous, power_state_override_enable} <= c[1:0];
        power_state_override_value <= ov;
        if (k != 2'h0)
            host(k, p);
        pulses(8, 1'h1, 1'h1);
        look(3);
        check(adaptive_on_time_mode, llm_exp(c, ov));
        @(posedge mclk);
        sense_code <= 16'h00F0;
        look(3);
        @(posedge mclk);
        sense_code <= 16'h0110;
    endtask : mode_case

    task automatic print_verdict;
        if (fails == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    //--------------------------------------------------------------
    // Sequence
    //--------------------------------------------------------------
    initial
    begin
        {reset_n, svid_mode, mgmt_bus_variant, mfr_aot_enable, force_continuous} <= 5'h00;
        {power_state_override_enable, pg_drop_on_zero, ref_ramping, cal_done} <= 4'h0;
        {switch_cycle, zero_cross, current_zero, feedback_input, pg_delay_en} <= 5'h04;
        {boot_in_tolerance, conversion_fault, cmd_go, cmd_kind, cmd_ps} <= 8'h00;
        {power_state_override_value, power_good_delay_command} <= 7'h00;
        {error_amp_code, on_width} <= 16'h0004;
        {input_supply_voltage, sense_code, ref_code, vout_code} <= 64'h0500_0110_0100_0100;
        {ov_warn_limit, uv_fault_limit, uv_warn_limit} <= 48'hFFFF_0000_0000;
        {pg_on_code, pg_off_code} <= 32'hFFFF_FFFF;
        look(19);
        check({adaptive_on_time_mode, cal_valid_ff, power_good_output, pg_oe_n}, 4'h0);
        @(posedge mclk);
        reset_n <= 1'h1;
        for (i = 0; i < 24; i++)
        begin
            @(posedge mclk);
            input_supply_voltage <= (i < 2) ? 16'h04B2 + 16'(i) : 16'($random(seed));
            sense_code     <= 16'($random(seed));
            ov_warn_limit  <= 16'($random(seed));
            uv_fault_limit <= 16'($random(seed));
            uv_warn_limit  <= 16'($random(seed));
            look(2);
            check(feed_forward_en, input_supply_voltage >= llm_pkg::FF_MIN_CODE);
            check(vout_telemetry_ff, sense_code);
            check({ov_warn_ff, uv_fault_ff, uv_warn_ff}, {sense_code > ov_warn_limit,
                  sense_code < uv_fault_limit, sense_code < uv_warn_limit});
        end
        @(posedge mclk);
        sense_code <= 16'h0110;
        calib(1'h0);
        pulses(8, 1'h1, 1'h1);
        look(3);
        check(adaptive_on_time_mode, 1'h0);
        pulses(1, 1'h1, 1'h0);
        calib(1'h1);
        look(1);
        check({cal_valid_ff, cal_dac_ff}, {1'h1, error_amp_code});
        pulses(7, 1'h1, 1'h1);
        pulses(1, 1'h1, 1'h0);
        pulses(7, 1'h1, 1'h1);
        look(3);
        check(adaptive_on_time_mode, 1'h0);
        pulses(1, 1'h1, 1'h1);
        look(3);
        check({adaptive_on_time_mode, high_side_drive, low_side_drive}, 3'h4);
        @(posedge mclk);
        {sense_code, current_zero} <= {16'h0100, 1'h0};
        look(4);
        check(high_side_drive, 1'h0);
        @(posedge mclk);
        current_zero <= 1'h1;
        @(posedge mclk);
        {sense_code, current_zero} <= {16'h0110, 1'h0};
        n = 0;
        for (i = 0; i < 20; i++)
        begin
            @(negedge mclk);
            if (high_side_drive === 1'h1)
                n++;
        end
        check(16'(n), 16'(on_width) + 16'h0001);
        check(low_side_drive, 1'h1);
        @(posedge mclk);
        current_zero <= 1'h1;
        look(2);
        check({adaptive_on_time_mode, low_side_drive}, 2'h2);
        @(posedge mclk);
        sense_code <= 16'h00F3;
        look(2);
        check(adaptive_on_time_mode, 1'h0);
        @(posedge mclk);
        sense_code <= 16'h0110;
        pulses(8, 1'h1, 1'h1);
        @(posedge mclk);
        {sense_code, current_zero} <= {16'h00FE, 1'h0};
        pulses(2, 1'h0, 1'h1);
        look(2);
        check(adaptive_on_time_mode, 1'h1);
        pulses(1, 1'h0, 1'h1);
        look(2);
        check(adaptive_on_time_mode, 1'h0);
        @(posedge mclk);
        {sense_code, current_zero} <= {16'h0110, 1'h1};
        pulses(8, 1'h1, 1'h1);
        @(posedge mclk);
        ref_ramping <= 1'h1;
        look(2);
        check(adaptive_on_time_mode, 1'h0);
        calib(1'h1);
        mode_case(5'h00, 3'h0, 2'h0, 3'h0);
        mode_case(5'h02, 3'h0, 2'h0, 3'h0);
        mode_case(5'h0C, 3'h0, 2'h0, 3'h0);
        mode_case(5'h08, 3'h0, 2'h0, 3'h0);
        mode_case(5'h10, 3'h0, 2'h0, 3'h0);
        for (i = 0; i < 7; i++)
            mode_case(5'h12, 3'h0, (i == 1) ? 2'h2 : 2'h1, 3'(i + 2));
        mode_case(5'h13, 3'h0, 2'h1, 3'h2);
        @(posedge mclk);
        {svid_mode, power_state_override_enable} <= 2'h0;
        force_continuous <= 1'h1;
        {pg_on_code, pg_off_code, sense_code} <= 48'h00E0_00D0_00D8;
        look(2);
        check(power_good_output, 1'h0);
        @(posedge mclk);
        sense_code <= 16'h00E8;
        look(1);
        check({power_good_output, pg_oe_n}, 2'h3);
        @(posedge mclk);
        sense_code <= 16'h00D8;
        look(2);
        check(power_good_output, 1'h1);
        @(posedge mclk);
        sense_code <= 16'h00C0;
        look(1);
        check({power_good_output, pg_oe_n}, 2'h0);
        @(posedge mclk);
        {pg_on_code, pg_off_code, sense_code} <= 48'h0010_0008_0050;
        look(2);
        check(power_good_output, 1'h0);
        @(posedge mclk);
        sense_code <= 16'h0070;
        look(2);
        check(power_good_output, 1'h1);
        @(posedge mclk);
        {sense_code, pg_delay_en, power_good_delay_command} <= {16'h0050, 1'h1, 4'h2};
        look(2);
        @(posedge mclk);
        sense_code <= 16'h0070;
        look(15);
        check(power_good_output, 1'h0);
        @(posedge mclk);
        sense_code <= 16'h0050;
        @(posedge mclk);
        sense_code <= 16'h0070;
        look(17);
        check(power_good_output, 1'h0);
        look(7);
        check(power_good_output, 1'h1);
        @(posedge mclk);
        {svid_mode, pg_delay_en, sense_code, boot_in_tolerance} <= {2'h2, 16'h0050, 1'h1};
        look(2);
        check(power_good_output, 1'h1);
        @(posedge mclk);
        {boot_in_tolerance, sense_code} <= {1'h0, 16'h0000};
        host(2'h3, 3'h0);
        look(3);
        check(power_good_output, 1'h1);
        @(posedge mclk);
        pg_drop_on_zero <= 1'h1;
        host(2'h3, 3'h0);
        look(1);
        check(power_good_output, 1'h0);
        @(posedge mclk);
        boot_in_tolerance <= 1'h1;
        look(2);
        @(posedge mclk);
        conversion_fault <= 1'h1;
        look(1);
        check(power_good_output, 1'h0);
        print_verdict();
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        fails++;
        print_verdict();
    end
endmodule : light_load_mode_and_power_good_control_bench
